// ---- smbus_cfg_loader.sv ----
// serial management slave plus power-up configuration loader
// assumes: SCL/SDA are open drain with board pull-ups; LINK_CLK runs free
//
// Function
// - slave active with mode pin high, or with it floating once loaded
// - slave address from base plus pins
// - data steady while clock high
// - detect start and stop edges
// - bus idle after free or high time
// - write: address, register, data, acked
// - read: repeated start, one byte, nack
// - floating mode pin makes device master
// - memory addressed at A0, 400 kHz
// - pins give sixteen distinct addresses
// - wait for load enable before loading
// - assert load done low, hold it
// - after load, return to slave service
// - first three bytes are common header
// - crc checked only when header enables
// - without map, start from address index
// - read exactly 37 data bytes
// - crc-8 poly 07 over 40 bytes
// - expected crc follows the data bytes
// - decode header flags and burst, byte 1 unused
// - mode pin low means pin control
`timescale 1ns/1ns
`default_nettype none
module smbus_cfg_loader
  import smbus_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic [1:0] SERIAL_MODE_SELECT,
  input wire logic [3:0] ADDR_PINS,
  input wire logic LOAD_ENABLE_N,
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic LOAD_DONE_N,
  output logic PIN_CONTROL_MODE,
  output logic LOAD_CRC_ERROR,
  input wire logic [5:0] CFG_RD_ADDR,
  output logic [7:0] CFG_RD_DATA
);
  // slave, master and loader-phase states
  typedef enum logic [5:0] {
    SL_IDLE = 6'h01, SL_RX = 6'h02, SL_RACK = 6'h04,
    SL_TX = 6'h08, SL_TACK = 6'h10, SL_IGNORE = 6'h20
  } sstate_t;
  typedef enum logic [9:0] {
    M_IDLE = 10'h001, M_START1 = 10'h002, M_DEVW = 10'h004,
    M_OFFH = 10'h008, M_OFFL = 10'h010, M_START2 = 10'h020,
    M_DEVR = 10'h040, M_READ = 10'h080, M_STOP = 10'h100,
    M_END = 10'h200
  } mstate_t;
  typedef enum logic [2:0] {
    P_HDR = 3'h1, P_MAP = 3'h2, P_DATA = 3'h4
  } lphase_t;

  // all link-domain state
  typedef struct packed {
    logic scl_p;
    logic sda_p;
    logic [10:0] hcnt;
    logic seen_stop;
    logic bus_idle;
    logic pin_ctl;
    sstate_t sst;
    logic [3:0] sbit;
    logic [7:0] ssh;
    logic [1:0] ssel;
    logic srd;
    logic [7:0] sptr;
    logic ssda_oe;
    logic req_tog;
    logic req_we;
    logic [7:0] req_addr;
    logic [7:0] req_data;
    mstate_t mst;
    logic [1:0] mph;
    logic [4:0] qcnt;
    logic [3:0] mbit;
    logic [7:0] msh;
    logic mscl_oe;
    logic msda_oe;
    lphase_t lph;
    logic [7:0] hdr0;
    logic [7:0] hdr2;
    logic [15:0] toff;
    logic [7:0] tcnt;
    logic [15:0] dstart;
    logic [5:0] dcnt;
    logic [7:0] crc;
    logic crc_err;
    logic done_n;
  } link_t;

  // all core-domain state
  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
    logic req_seen;
    logic ack_tog;
    logic [7:0] rd_data;
    logic [7:0] cfg_rd_data;
  } core_t;

  link_t l;
  link_t next_l;
  core_t c;
  core_t next_c;
  logic link_rst_n; // reset as seen in the link domain
  logic [8:0] pins_s; // synchronised pins
  logic [1:0] mode_s;
  logic [3:0] ad_s;
  logic len_s;
  logic scl_s;
  logic sda_s;
  logic req_s; // request toggle in core domain
  logic ack_s; // answer toggle in link domain
  logic [7:0] crc_nx; // crc after the byte in the master shifter
  logic [6:0] own; // own 7-bit slave address
  logic slave_en;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////
  // crossings
  sync2 #(.W(1), .INIT(1'b0)) u_rst_sync (
    .clk(LINK_CLK), .rst_n(1'b1), .d(RST_N), .q(link_rst_n));
  // reset code shows an unused mode, so no mode output pulses after reset
  sync2 #(.W(9), .INIT(9'h187)) u_pin_sync (
    .clk(LINK_CLK), .rst_n(link_rst_n),
    .d({SERIAL_MODE_SELECT, ADDR_PINS, LOAD_ENABLE_N, SCL_I, SDA_I}),
    .q(pins_s));
  sync2 #(.W(1), .INIT(1'b0)) u_req_sync (
    .clk(CLK), .rst_n(RST_N), .d(l.req_tog), .q(req_s));
  sync2 #(.W(1), .INIT(1'b0)) u_ack_sync (
    .clk(LINK_CLK), .rst_n(link_rst_n), .d(c.ack_tog), .q(ack_s));
  crc8_step u_crc (.crc_in(l.crc), .data_in(l.msh), .crc_out(crc_nx));

  assign {mode_s, ad_s, len_s, scl_s, sda_s} = pins_s;
  assign own =
    {SLAVE_ADDR_BASE + {3'h0, ad_s[3]}, ad_s[2:0]};
  // slave serves in slave mode, or in master mode once loaded
  assign slave_en = (mode_s == MODE_SLAVE) ||
    (mode_s == MODE_MASTER && !l.done_n);
  assign start_c = scl_s && l.scl_p && l.sda_p && !sda_s;
  assign stop_c = scl_s && l.scl_p && !l.sda_p && sda_s;
  assign rise = scl_s && !l.scl_p;
  assign fall = !scl_s && l.scl_p;

  ////////////////////////////////////////////////////////////////////////
  // core domain: register file, serves one request per toggle
  always_comb
  begin
    next_c = c;
    next_c.cfg_rd_data = c.regs[CFG_RD_ADDR];
    if (req_s != c.req_seen)
    begin
      next_c.req_seen = req_s;
      next_c.ack_tog = !c.ack_tog;
      if (l.req_we && l.req_addr < REG_LIMIT)
        next_c.regs[l.req_addr[5:0]] = l.req_data;
      else if (!l.req_we)
        next_c.rd_data = (l.req_addr < REG_LIMIT) ?
          c.regs[l.req_addr[5:0]] : 8'h00;
    end
    if (!RST_N)
    begin
      next_c = '0;
      for (int i = 0; i < REG_COUNT; i++)
        next_c.regs[i] = REG_RESET;
    end
  end

  always_ff @(posedge CLK)
  begin
    c <= next_c;
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: bus watch, slave, master and loader
  always_comb
  begin
    logic qtick;
    logic op_done;
    logic mrd;
    logic [15:0] start_v;
    logic [5:0] left_v;
    qtick = (l.qcnt == EE_QUARTER_CYC - 5'h01);
    op_done = 1'b0;
    mrd = (l.mst == M_READ);
    start_v = l.dstart;
    left_v = DEV_STRIDE - l.dcnt;
    next_l = l;
    next_l.scl_p = scl_s;
    next_l.sda_p = sda_s;
    next_l.pin_ctl = (mode_s == MODE_PIN);
    // idle detection on both lines high
    if (scl_s && sda_s)
      next_l.hcnt = (l.hcnt == 11'h7FF) ? l.hcnt : l.hcnt + 11'h001;
    else
      next_l.hcnt = 11'h000;
    if (stop_c)
      next_l.seen_stop = 1'b1;
    else if (start_c)
      next_l.seen_stop = 1'b0;
    next_l.bus_idle = (l.seen_stop && l.hcnt > T_BUF_CYC) ||
      (l.hcnt > T_HIGH_CYC);

    // slave engine
    if (!slave_en)
    begin
      next_l.sst = SL_IDLE;
      next_l.ssda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_l.sst = SL_IDLE;
      next_l.ssda_oe = 1'b0;
    end
    else if (start_c)
    begin
      next_l.sst = SL_RX;
      next_l.sbit = 4'h0;
      next_l.ssel = 2'h0;
      next_l.srd = 1'b0;
      next_l.ssda_oe = 1'b0;
    end
    else
    begin
      unique case (l.sst)
        SL_IDLE, SL_IGNORE:
          next_l.ssda_oe = 1'b0;
        SL_RX:
        begin
          if (rise)
          begin
            next_l.ssh = {l.ssh[6:0], sda_s};
            next_l.sbit = l.sbit + 4'h1;
          end
          else if (fall && l.sbit == 4'h8)
          begin
            next_l.sbit = 4'h0;
            next_l.sst = SL_RACK;
            next_l.ssda_oe = 1'b1;
            if (l.ssel == 2'h0 && l.ssh[7:1] != own)
            begin
              next_l.sst = SL_IGNORE;
              next_l.ssda_oe = 1'b0;
            end
            else if (l.ssel == 2'h0)
            begin
              next_l.srd = l.ssh[0];
              if (l.ssh[0])
              begin
                next_l.req_tog = !l.req_tog;
                next_l.req_we = 1'b0;
                next_l.req_addr = l.sptr;
              end
            end
            else if (l.ssel == 2'h1)
              next_l.sptr = l.ssh;
            else
            begin
              next_l.req_tog = !l.req_tog;
              next_l.req_we = 1'b1;
              next_l.req_addr = l.sptr;
              next_l.req_data = l.ssh;
            end
          end
        end
        SL_RACK:
          if (fall && l.srd)
          begin
            next_l.ssh = c.rd_data;
            next_l.ssda_oe = !c.rd_data[7];
            next_l.sst = SL_TX;
          end
          else if (fall)
          begin
            next_l.ssda_oe = 1'b0;
            next_l.ssel = l.ssel + 2'h1;
            next_l.sst = (l.ssel == 2'h2) ? SL_IGNORE : SL_RX;
          end
        SL_TX:
          if (fall && l.sbit == 4'h7)
          begin
            next_l.ssda_oe = 1'b0;
            next_l.sst = SL_TACK;
          end
          else if (fall)
          begin
            next_l.sbit = l.sbit + 4'h1;
            next_l.ssh = {l.ssh[6:0], 1'b0};
            next_l.ssda_oe = !l.ssh[6];
          end
        SL_TACK:
          if (rise)
            next_l.sst = SL_IGNORE;
        default:
          next_l.sst = SL_IDLE;
      endcase
    end

    // master bit engine: four quarter phases per bit or condition
    if (l.mst != M_IDLE && l.mst != M_END)
    begin
      next_l.qcnt = qtick ? 5'h00 : l.qcnt + 5'h01;
      if (qtick)
      begin
        next_l.mph = l.mph + 2'h1;
        unique case (l.mph)
          2'h0:
            if (l.mst == M_START1 || l.mst == M_START2)
              next_l.msda_oe = 1'b0;
            else if (l.mst == M_STOP)
              next_l.msda_oe = 1'b1;
            else if (l.mbit == 4'h8)
              next_l.msda_oe = mrd && l.tcnt != 8'h01;
            else
              next_l.msda_oe = !mrd && !l.msh[7];
          2'h1:
            next_l.mscl_oe = 1'b0;
          2'h2:
            if (l.mst == M_START1 || l.mst == M_START2)
              next_l.msda_oe = 1'b1;
            else if (l.mst == M_STOP)
              next_l.msda_oe = 1'b0;
            else if (l.mbit != 4'h8)
              next_l.msh = {l.msh[6:0], sda_s};
          default:
          begin
            next_l.mscl_oe = (l.mst != M_STOP);
            if (l.mst == M_START1 || l.mst == M_START2 ||
                l.mst == M_STOP || l.mbit == 4'h8)
            begin
              op_done = 1'b1;
              next_l.mbit = 4'h0;
            end
            else
              next_l.mbit = l.mbit + 4'h1;
          end
        endcase
      end
    end

    // loader sequencing between operations
    unique case (l.mst)
      M_IDLE:
        if (mode_s == MODE_MASTER && !len_s && l.bus_idle && l.done_n)
        begin
          next_l.mst = M_START1;
          next_l.lph = P_HDR;
          next_l.toff = 16'h0000;
          next_l.tcnt = {5'h00, HDR_BYTES[2:0]};
          next_l.crc = CRC_INIT;
          next_l.qcnt = 5'h00;
          next_l.mph = 2'h0;
        end
      M_START1:
        if (op_done)
        begin
          next_l.mst = M_DEVW;
          next_l.msh = {EE_ADDR_BYTE[7:1], 1'b0};
        end
      M_DEVW:
        if (op_done)
        begin
          next_l.mst = (l.lph != P_HDR && l.hdr0[HDR_BIG_BIT]) ?
            M_OFFH : M_OFFL;
          next_l.msh = (l.lph != P_HDR && l.hdr0[HDR_BIG_BIT]) ?
            l.toff[15:8] : l.toff[7:0];
        end
      M_OFFH:
        if (op_done)
        begin
          next_l.mst = M_OFFL;
          next_l.msh = l.toff[7:0];
        end
      M_OFFL:
        if (op_done)
          next_l.mst = M_START2;
      M_START2:
        if (op_done)
        begin
          next_l.mst = M_DEVR;
          next_l.msh = {EE_ADDR_BYTE[7:1], 1'b1};
        end
      M_DEVR:
        if (op_done)
          next_l.mst = M_READ;
      M_READ:
        if (op_done)
        begin
          next_l.tcnt = l.tcnt - 8'h01;
          next_l.mst = (l.tcnt == 8'h01) ? M_STOP : M_READ;
          unique case (l.lph)
            P_HDR:
            begin
              next_l.crc = crc_nx;
              if (l.tcnt == 8'h03)
                next_l.hdr0 = l.msh;
              if (l.tcnt == 8'h01)
                next_l.hdr2 = l.msh;
            end
            P_MAP:
              next_l.dstart = {8'h00, l.msh};
            default:
            begin
              next_l.dcnt = l.dcnt + 6'h01;
              if (l.dcnt < CFG_DATA_BYTES)
              begin
                next_l.crc = crc_nx;
                next_l.req_tog = !l.req_tog;
                next_l.req_we = 1'b1;
                next_l.req_addr = {2'h0, l.dcnt};
                next_l.req_data = l.msh;
              end
              else
                next_l.crc_err = l.hdr0[HDR_CRC_EN_BIT] &&
                  (l.msh != l.crc);
            end
          endcase
        end
      M_STOP:
        if (op_done && l.lph == P_HDR && l.hdr0[HDR_MAP_BIT])
        begin
          next_l.lph = P_MAP;
          next_l.toff = {8'h00, MAP_BASE + {3'h0, ad_s, 1'b0}};
          next_l.tcnt = 8'h01;
          next_l.mst = M_START1;
        end
        else if (op_done)
        begin
          if (l.lph == P_HDR)
            start_v = 16'(HDR_BYTES) +
              {12'h000, ad_s} * {10'h000, DEV_STRIDE};
          next_l.dstart = start_v;
          next_l.lph = P_DATA;
          if (l.lph == P_DATA && l.dcnt == DEV_STRIDE)
          begin
            next_l.mst = M_END;
            next_l.done_n = 1'b0;
          end
          else
          begin
            next_l.mst = M_START1;
            next_l.toff = start_v + {10'h000, l.dcnt};
            next_l.tcnt = (l.hdr2 != 8'h00 && l.hdr2 < {2'h0, left_v}) ?
              l.hdr2 : {2'h0, left_v};
          end
        end
      M_END:
        next_l.done_n = 1'b0;
      default:
        next_l.mst = M_IDLE;
    endcase

    if (!link_rst_n)
    begin
      next_l = '0;
      next_l.scl_p = 1'b1;
      next_l.sda_p = 1'b1;
      next_l.seen_stop = 1'b1;
      next_l.sst = SL_IDLE;
      next_l.mst = M_IDLE;
      next_l.lph = P_HDR;
      next_l.done_n = 1'b1;
    end
  end

  always_ff @(posedge LINK_CLK)
  begin
    l <= next_l;
  end

  // open-drain pins only ever pull low
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = l.mscl_oe;
  assign SDA_OE = l.ssda_oe || l.msda_oe;
  assign LOAD_DONE_N = l.done_n;
  assign PIN_CONTROL_MODE = l.pin_ctl;
  assign LOAD_CRC_ERROR = l.crc_err;
  assign CFG_RD_DATA = c.cfg_rd_data;

  ////////////////////////////////////////////////////////////////////////
  // checks on the link domain
  default clocking cb @(posedge LINK_CLK);
  endclocking
  default disable iff (!link_rst_n);

  a_slave_gated: assert property (
    l.sst != SL_IDLE |-> $past(slave_en)) else $error("slave ran while off");
  a_own_match: assert property (
    slave_en && l.sst == SL_RX && fall && l.sbit == 4'h8 &&
    l.ssel == 2'h0 && l.ssh[7:1] == own |=> l.sst == SL_RACK && l.ssda_oe)
    else $error("own address not acked");
  a_sda_steady: assert property (
    !l.mscl_oe && (l.mst == M_DEVW || l.mst == M_READ || l.mst == M_OFFL)
    |-> $stable(l.msda_oe)) else $error("data moved with clock high");
  a_start_seen: assert property (
    slave_en && start_c |=> l.sst == SL_RX && l.sbit == 4'h0)
    else $error("start not taken");
  a_bus_idle: assert property (
    $rose(l.bus_idle) |-> $past(l.hcnt) > T_BUF_CYC)
    else $error("bus idle too early");
  a_read_ready: assert property (
    l.sst == SL_RACK && fall && l.srd |-> ack_s == l.req_tog)
    else $error("read data not ready");
  a_foreign_addr: assert property (
    slave_en && l.sst == SL_RX && fall && l.sbit == 4'h8 &&
    l.ssel == 2'h0 && l.ssh[7:1] != own |=> l.sst == SL_IGNORE [*2])
    else $error("foreign address answered");
  a_load_wait: assert property (
    l.mst == M_IDLE && len_s |=> l.mst == M_IDLE)
    else $error("load began without enable");
  a_done_hold: assert property (
    !l.done_n |=> !l.done_n) else $error("load done released");
  a_ee_addr: assert property (
    $rose(l.mst == M_DEVW) |-> l.msh == {EE_ADDR_BYTE[7:1], 1'b0})
    else $error("wrong memory address");
  a_hdr_fetch: assert property (
    $rose(l.mst == M_START1) && l.lph == P_HDR |->
    l.toff == 16'h0000 && l.tcnt == 8'h03) else $error("bad header fetch");
  a_crc_gate: assert property (
    l.crc_err |-> l.hdr0[HDR_CRC_EN_BIT]) else $error("crc flagged off");
  a_data_count: assert property (
    $fell(l.done_n) |-> l.dcnt == DEV_STRIDE) else $error("short load");
  a_burst_cap: assert property (
    $rose(l.mst == M_START1) && l.lph == P_DATA && l.hdr2 != 8'h00 |->
    l.tcnt <= l.hdr2) else $error("burst too long");
endmodule
`default_nettype wire

// ---- smbus_cfg_pkg.sv ----
// constants shared by the serial management block and its helpers
// assumes: no other package defines these names
package smbus_cfg_pkg;
  // three-level mode pin as seen by the pad decoder
  localparam logic [1:0] MODE_PIN = 2'h0;
  localparam logic [1:0] MODE_MASTER = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  // slave address upper nibble before the top address pin is added
  localparam logic [3:0] SLAVE_ADDR_BASE = 4'hB;
  // address byte of the configuration memory, write form
  localparam logic [7:0] EE_ADDR_BYTE = 8'hA0;
  // header byte 0 field positions
  localparam int HDR_CRC_EN_BIT = 7;
  localparam int HDR_MAP_BIT = 6;
  localparam int HDR_BIG_BIT = 5;
  // image layout
  localparam logic [7:0] HDR_BYTES = 8'h03;
  localparam logic [5:0] CFG_DATA_BYTES = 6'h25;
  localparam logic [5:0] DEV_STRIDE = 6'h26;
  localparam logic [7:0] MAP_BASE = 8'h04;
  // crc-8, x^8+x^2+x+1
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // configuration register file
  localparam int REG_COUNT = 64;
  localparam logic [7:0] REG_LIMIT = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;
  // link timing, in ns, and derived link-clock counts
  localparam int LINK_PERIOD_NS = 30;
  localparam int T_BUF_NS = 4700;
  localparam int T_HIGH_MAX_NS = 50000;
  localparam int EE_SCL_PERIOD_NS = 2500;
  localparam logic [10:0] T_BUF_CYC =
    11'((T_BUF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [10:0] T_HIGH_CYC = 11'(T_HIGH_MAX_NS / LINK_PERIOD_NS);
  // rounded up so the loader never clocks faster than the memory's rating
  localparam logic [4:0] EE_QUARTER_CYC =
    5'((EE_SCL_PERIOD_NS + 4 * LINK_PERIOD_NS - 1) / (4 * LINK_PERIOD_NS));
endpackage

// ---- sync2.sv ----
// two-flop synchroniser for a bundle of levels
// assumes: each bit is a slow level or a toggle, never a multi-bit word
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // both stages; the first is read only by the second
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;
  sync_t r;
  sync_t next_r;

  ////////////////////////////////////////////////////////////////////////
  // shift the sample through two stages
  always_comb
  begin
    next_r = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    if (!rst_n)
    begin
      next_r.s1 = INIT;
      next_r.s2 = INIT;
    end
  end

  // synchronous reset, every edge
  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  assign q = r.s2;
endmodule
`default_nettype wire

// ---- crc8_step.sv ----
// one-byte crc-8 update, msb first
// assumes: caller registers the result
`timescale 1ns/1ns
`default_nettype none
module crc8_step
  import smbus_cfg_pkg::*;
(
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  ////////////////////////////////////////////////////////////////////////
  // eight shift-and-reduce steps
  always_comb
  begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_out = c;
  end
endmodule
`default_nettype wire

// ---- cfg_eeprom_model.sv ----
// behavioural configuration memory on the shared two-wire bus
// assumes: the bench resolves the open-drain wires with pull-ups
`timescale 1ns/1ns
`default_nettype none
module cfg_eeprom_model
  import smbus_cfg_pkg::*;
(
  input wire logic SCL,
  input wire logic SDA,
  output logic SDA_LOW
);
  logic [7:0] mem [256]; // image, filled by the bench
  logic [7:0] sr, sh, ptr; // shift in, shift out, byte pointer
  logic act = 1'b0; // inside a message
  logic first, sel, rd, rdp, mack; // message state
  int cnt = 0; // bit slot within a byte
  initial SDA_LOW = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // start resets the message, stop ends it
  always @(negedge SDA)
    if (SCL)
    begin
      act = 1'b1;
      first = 1'b1;
      sel = 1'b0;
      rdp = 1'b0;
      cnt = 0;
      SDA_LOW = 1'b0;
    end
  always @(posedge SDA)
    if (SCL)
      act = 1'b0;
  // take data bits and the master's ack on the clock rise
  always @(posedge SCL)
    if (act)
    begin
      if (cnt < 8)
        sr = {sr[6:0], SDA};
      else
        mack = SDA;
      cnt++;
    end
  // line changes only while the clock is low
  always @(negedge SCL)
    if (act)
    begin
      if (cnt == 8 && !rdp)
      begin
        if (first)
        begin
          sel = sr[7:1] == EE_ADDR_BYTE[7:1];
          rd = sr[0];
        end
        else if (sel)
          ptr = sr;
        first = 1'b0;
        SDA_LOW = sel;
      end
      else if (cnt == 9)
      begin
        cnt = 0;
        if (rdp && mack)
          sel = 1'b0;
        rdp = sel && rd;
        sh = mem[ptr];
        if (rdp)
          ptr++;
        SDA_LOW = rdp && !sh[7];
      end
      else
        SDA_LOW = rdp && cnt < 8 && !sh[7 - cnt];
    end
endmodule
`default_nettype wire

// ---- smbus_cfg_loader_tb.sv ----
// bench: power-up load from the memory model, then host register access
// assumes: package, design and memory model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module smbus_cfg_loader_tb
  import smbus_cfg_pkg::*;
;
  logic clk, link_clk, rst_n, en_n, hs, hd; // hs/hd: host pulls low
  logic [1:0] mode;
  logic [3:0] ad;
  logic [5:0] rd_addr;
  wire logic scl_oe, sda_oe, ee_low, done_n, pcm, crc_err;
  wire logic [7:0] rd_data;
  wire logic scl = !(scl_oe || hs); // wired-and with pull-up
  wire logic sda = !(sda_oe || hd || ee_low);
  int ref_reg [64]; // expected register file
  int n_mismatch = 0;
  int tests_run = 0;
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  smbus_cfg_loader dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
    .SERIAL_MODE_SELECT(mode), .ADDR_PINS(ad), .LOAD_ENABLE_N(en_n),
    .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(),
    .SDA_OE(sda_oe), .LOAD_DONE_N(done_n), .PIN_CONTROL_MODE(pcm),
    .LOAD_CRC_ERROR(crc_err), .CFG_RD_ADDR(rd_addr), .CFG_RD_DATA(rd_data));
  cfg_eeprom_model ee (.SCL(scl), .SDA(sda), .SDA_LOW(ee_low));
  ////////////////////////////////////////////////////////////////////////
  // wait n clocks, then step just past the edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // host bus conditions and bits, 1 us low phases
  task automatic hstart();
    hd = 1'b0;
    w(25);
    hs = 1'b0;
    w(25);
    hd = 1'b1;
    w(25);
    hs = 1'b1;
  endtask
  task automatic hbit(input logic b, output logic r);
    hd = !b;
    w(25);
    hs = 1'b0;
    w(12);
    r = sda;
    w(13);
    hs = 1'b1;
  endtask
  task automatic hbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      hbit(d[i], r[i]);
  endtask
  // one register write, or a pointer write plus read-back
  task automatic xfer(input logic [7:0] a, input logic [7:0] r,
    input logic [7:0] v, input logic rdo, output logic [7:0] got,
    output logic [2:0] ack);
    logic [8:0] x, y;
    hstart();
    hbyte({a, 1'b1}, x);
    ack[2] = x[0];
    hbyte({r, 1'b1}, x);
    ack[1] = x[0];
    if (rdo)
    begin
      hstart();
      hbyte({a | 8'h01, 1'b1}, x);
      hbyte(9'h1FF, y);
      got = y[8:1];
    end
    else
      hbyte({v, 1'b1}, x);
    ack[0] = x[0];
    hd = 1'b1;
    w(25);
    hs = 1'b0;
    w(25);
    hd = 1'b0;
    w(25);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c,
    input logic [7:0] d);
    c = c ^ d;
    repeat (8) c = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic chk_regs();
    for (int k = 0; k < 64; k++)
    begin
      rd_addr = 6'(k);
      w(2);
      chk("cfg register", ref_reg[k][7:0], rd_data);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence: two loads, then host access on two addresses
  initial
  begin
    logic [7:0] crc, r, v, got, own;
    logic [2:0] acks;
    int base;
    {rst_n, en_n, hs, hd, rd_addr, ad} = {4'h4, 6'h00, 4'h0};
    mode = MODE_MASTER;
    void'($urandom(32'h8b7c));
    for (int p = 0; p < 2; p++)
    begin
      rst_n = 1'b0;
      en_n = 1'b1;
      ad = 4'(p);
      base = 3 + 38 * p;
      for (int i = 0; i < 256; i++)
        ee.mem[i] = 8'($urandom);
      ee.mem[0] = p ? 8'hE2 : 8'h82;
      ee.mem[2] = p ? 8'h0D : 8'h00;
      ee.mem[4 + 2 * p] = 8'(base);
      crc = CRC_INIT;
      for (int i = 0; i < 40; i++)
        crc = crc8(crc, ee.mem[i < 3 ? i : base + i - 3]);
      ee.mem[base + 37] = crc ^ 8'(p);
      for (int k = 0; k < 64; k++)
        ref_reg[k] = k < 37 ? ee.mem[base + k] : 0;
      w(3);
      rst_n = 1'b1;
      w(300);
      chk("done before enable", 8'h01, 8'(done_n));
      en_n = 1'b0;
      for (int n = 0; n < 60000 && done_n !== 1'b0; n++)
        w(1);
      chk("load done", 8'h00, 8'(done_n));
      chk("crc error", 8'(p), 8'(crc_err));
      chk_regs();
    end
    for (int q = 0; q < 2; q++)
    begin
      ad = q ? 4'h8 | 4'($urandom_range(7)) : 4'h1;
      own = {SLAVE_ADDR_BASE + {3'h0, ad[3]}, ad[2:0], 1'b0};
      r = 8'($urandom_range(63));
      v = 8'($urandom);
      w(10);
      xfer(own, r, v, 1'b0, got, acks);
      chk("write acks", 8'h00, 8'(acks));
      ref_reg[r] = v;
      xfer(own ^ 8'h04, r, ~v, 1'b0, got, acks);
      chk("foreign acks", 8'h07, 8'(acks));
      xfer(own, r, 8'h00, 1'b1, got, acks);
      chk("read acks", 8'h00, 8'(acks));
      chk("read data", ref_reg[r][7:0], got);
    end
    chk_regs();
    mode = MODE_PIN;
    w(10);
    chk("pin control", 8'h01, 8'(pcm));
    chk("done held", 8'h00, 8'(done_n));
    xfer(own, r, ~v, 1'b0, got, acks);
    chk("off acks", 8'h07, 8'(acks));
    mode = MODE_SLAVE;
    w(10);
    xfer(own, r, 8'h00, 1'b1, got, acks);
    chk("slave acks", 8'h00, 8'(acks));
    chk("slave read", ref_reg[r][7:0], got);
    end_sim();
  end
  // watchdog against a hung load or bus
  initial
  begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
